// ==== rtl/bridge_pkg.sv ====
package bridge_pkg;
   // ========================================
   // Register map
   localparam int AXI_AW = 8;
   localparam logic [AXI_AW-1:0] OFS_BUF = 8'h00;
   localparam logic [AXI_AW-1:0] OFS_STAT = 8'h04;
   localparam logic [AXI_AW-1:0] OFS_DEC = 8'h44;
   localparam logic [AXI_AW-1:0] OFS_DOCK = 8'h5c;
   localparam int B_POST = 0;
   localparam int B_IOPOST = 1;
   localparam int B_LBEN = 2;
   localparam int B_SUBTR = 6;
   localparam int B_DOCK = 0;
   localparam int S_MABT = 0;
   localparam int S_PERR = 1;
   localparam int S_PWB = 2;
   localparam int S_LBW = 3;
   localparam int S_GNT = 4;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ========================================
   // PCI commands and line geometry
   localparam logic [3:0] CMD_IOR = 4'h2;
   localparam logic [3:0] CMD_IOW = 4'h3;
   localparam logic [3:0] CMD_MR = 4'h6;
   localparam logic [3:0] CMD_MW = 4'h7;
   localparam logic [3:0] CMD_MWI = 4'hf;
   localparam int LINE_BYTES = 8;
   localparam int WR_BYTES = 4;
   localparam int LINE_AW = 3;
   localparam logic [31:0] LINE_MASK = 32'h0000_0007;
   localparam logic [31:0] DW_STEP = 32'h0000_0004;
   localparam logic [3:0] BE_ALL = 4'hf;
   // ========================================
   // Carriers
   typedef struct packed {
      logic [3:0] cmd;
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] be;
      logic cfg;
      logic ide;
      logic usb;
      logic inta;
      logic int_io;
      logic dma_reg;
      logic io_post;
      logic other;
   } tgt_req_t;
   typedef struct packed {
      logic valid;
      logic claim;
      logic subtr;
      logic retry;
      logic post;
   } tgt_rsp_t;
   typedef struct packed {
      logic drive;
      logic [31:0] ad;
      logic [3:0] cbe_n;
   } tgt_dph_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] be;
      logic io;
   } isa_wr_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] be;
      logic write;
      logic mem;
   } lb_req_t;
   typedef struct packed {
      logic [3:0] cmd;
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] cbe_n;
      logic apar;
      logic dpar;
   } mst_req_t;
   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_F0 = 3'b001,
      L_F1 = 3'b011,
      L_RESP = 3'b010,
      L_FLUSH = 3'b110,
      L_PASS = 3'b111
   } lb_st_t;
endpackage

// ==== rtl/pci_isa_buffer_decode.sv ====
// What this block does
// - Post PCI-to-ISA memory writes when enabled
// - Retry claimed cycles while posted buffer full
// - Optionally post I/O data writes too
// - Drain, disable posting before ISA master grant
// - Master abort on DEVSEL timeout
// - ISA/DMA memory access makes us initiator
// - Only ISA/DMA memory cycles use line buffer
// - Reads prefetch two dwords, writes four bytes
// - Buffer disabled: pass accesses through in order
// - Read miss fetches eight bytes
// - Bytes supplied on hit become invalid
// - Prefetch on empty, miss or invalid byte
// - Full write line flushes and empties
// - Write miss on partial line flushes first
// - Write hitting valid bytes flushes first
// - Read after partial write flushes first
// - DACK release after partial write flushes
// - Initiator parity generate, read parity check
// - Target read parity, one clock after data
// - Positive decode; select bit for internal cycles
// - Everything else claimed subtractively, except cycles flagged other, which go unclaimed
// - Docking mode decodes all cycles positively
`timescale 1ns/1ps
`default_nettype none
module pci_isa_buffer_decode #(
   parameter int MABORT_CLKS = 5
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [bridge_pkg::AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [bridge_pkg::AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic tgt_valid,
   input wire bridge_pkg::tgt_req_t tgt_req,
   output bridge_pkg::tgt_rsp_t tgt_rsp,
   input wire bridge_pkg::tgt_dph_t tgt_dph,
   output logic tgt_par,
   output logic tgt_par_oe,
   output logic isa_wr_valid,
   output bridge_pkg::isa_wr_t isa_wr,
   input wire logic isa_wr_ready,
   input wire logic isa_mreq,
   output logic isa_gnt,
   input wire logic dack_n,
   input wire logic lb_valid,
   input wire bridge_pkg::lb_req_t lb_req,
   output logic lb_done,
   output logic [31:0] lb_rdata,
   output logic mst_valid,
   output bridge_pkg::mst_req_t mst_req,
   input wire logic mst_devsel,
   input wire logic mst_done,
   input wire logic [31:0] mst_rdata,
   input wire logic mst_rpar
);
   import bridge_pkg::*;

   localparam int TW = $clog2(MABORT_CLKS + 1);
   localparam logic [TW-1:0] TMO_LIM = TW'(MABORT_CLKS - 1);

   logic post_en_q, iopost_en_q, lb_en_q, subtr_sel_q, dock_q;
   logic mabt_q, perr_q;
   logic aw_h_q, w_h_q;
   logic [AXI_AW-1:0] awa_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   logic wr_go, stat_clr;
   logic [31:0] rd_d;
   logic rd_ok;
   logic pos, claim, isa_bound, memwr, iowr, postable;
   lb_st_t st_q;
   logic [LINE_BYTES-1:0][7:0] line_q;
   logic [LINE_BYTES-1:0] rv_q, reqm;
   logic [31:LINE_AW] tag_q;
   logic [31:2] wtag_q;
   logic [WR_BYTES-1:0] wmask_q;
   logic use_lb, wpart, wfull, w_conf, hit;
   logic dsel_q, op_end, abort;
   logic [TW-1:0] tmo_q;
   logic [31:0] rdat;
   logic dack_q, dflush_q, last_wr_q, chk_q, exp_q;

   function automatic mst_req_t mk(input logic [3:0] c, input logic [31:0] a,
                                   input logic [31:0] d, input logic [3:0] bn);
      mst_req_t m;
      m.cmd = c;
      m.addr = a;
      m.data = d;
      m.cbe_n = bn;
      m.apar = ^{a, c};
      m.dpar = ^{d, bn};
      return m;
   endfunction

   // ========================================
   // Register bus
   assign wr_go = aw_h_q & w_h_q;
   assign stat_clr = wr_go && awa_q == OFS_STAT && ws_q[0];

   always_ff @(posedge mclk) begin
      if (reset) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_h_q <= 1'b0;
         w_h_q <= 1'b0;
         awa_q <= '0;
         wd_q <= '0;
         ws_q <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OK;
         post_en_q <= 1'b0;
         iopost_en_q <= 1'b0;
         lb_en_q <= 1'b0;
         subtr_sel_q <= 1'b0;
         dock_q <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_h_q <= 1'b1;
            awa_q <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_h_q <= 1'b1;
            wd_q <= wdata;
            ws_q <= wstrb;
         end
         if (wr_go) begin
            aw_h_q <= 1'b0;
            w_h_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= RESP_OK;
            unique case (awa_q)
               OFS_BUF: if (ws_q[0]) begin
                  post_en_q <= wd_q[B_POST];
                  iopost_en_q <= wd_q[B_IOPOST];
                  lb_en_q <= wd_q[B_LBEN];
               end
               OFS_DEC: if (ws_q[0]) subtr_sel_q <= wd_q[B_SUBTR];
               OFS_DOCK: if (ws_q[0]) dock_q <= wd_q[B_DOCK];
               OFS_STAT: ;
               default: bresp <= RESP_SLVERR;
            endcase
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   always_comb begin
      rd_d = '0;
      rd_ok = 1'b1;
      unique case (araddr)
         OFS_BUF: begin
            rd_d[B_POST] = post_en_q;
            rd_d[B_IOPOST] = iopost_en_q;
            rd_d[B_LBEN] = lb_en_q;
         end
         OFS_STAT: begin
            rd_d[S_MABT] = mabt_q;
            rd_d[S_PERR] = perr_q;
            rd_d[S_PWB] = isa_wr_valid;
            rd_d[S_LBW] = wpart;
            rd_d[S_GNT] = isa_gnt;
         end
         OFS_DEC: rd_d[B_SUBTR] = subtr_sel_q;
         OFS_DOCK: rd_d[B_DOCK] = dock_q;
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OK;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_d;
         rresp <= rd_ok ? RESP_OK : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Sticky flags: a new event beats a same-cycle clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         mabt_q <= 1'b0;
         perr_q <= 1'b0;
      end else begin
         mabt_q <= abort | (mabt_q & ~(stat_clr & wd_q[S_MABT]));
         perr_q <= (chk_q & (mst_rpar != exp_q)) | (perr_q & ~(stat_clr & wd_q[S_PERR]));
      end
   end

   // ========================================
   // Target decode and posted write buffer
   assign pos = dock_q | tgt_req.cfg | tgt_req.ide | tgt_req.usb
                | ((tgt_req.inta | tgt_req.int_io) & ~subtr_sel_q);
   assign claim = pos | (~dock_q & ~tgt_req.other);
   assign isa_bound = ~(tgt_req.cfg | tgt_req.ide | tgt_req.usb | tgt_req.inta
                        | tgt_req.int_io | tgt_req.dma_reg);
   assign memwr = tgt_req.cmd == CMD_MW || tgt_req.cmd == CMD_MWI;
   assign iowr = tgt_req.cmd == CMD_IOW && tgt_req.io_post && iopost_en_q;
   // No posting once an ISA master asks, so the grant waits only for the drain
   assign postable = tgt_valid & claim & isa_bound & post_en_q & ~isa_mreq & ~isa_gnt
                     & ~isa_wr_valid & (memwr | iowr);

   always_ff @(posedge mclk) begin
      if (reset) begin
         tgt_rsp <= '0;
      end else begin
         tgt_rsp.valid <= tgt_valid;
         tgt_rsp.claim <= tgt_valid & claim;
         tgt_rsp.subtr <= tgt_valid & claim & ~pos;
         tgt_rsp.retry <= tgt_valid & claim & isa_wr_valid;
         tgt_rsp.post <= postable;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         isa_wr_valid <= 1'b0;
         isa_wr <= '0;
         isa_gnt <= 1'b0;
      end else begin
         if (postable) begin
            isa_wr_valid <= 1'b1;
            isa_wr <= '{addr: tgt_req.addr, data: tgt_req.data, be: tgt_req.be, io: iowr};
         end else if (isa_wr_valid && isa_wr_ready) begin
            isa_wr_valid <= 1'b0;
         end
         isa_gnt <= isa_mreq & (isa_gnt | ~isa_wr_valid);
      end
   end

   // Target read parity trails its data by one clock
   always_ff @(posedge mclk) begin
      if (reset) begin
         tgt_par <= 1'b0;
         tgt_par_oe <= 1'b0;
      end else begin
         tgt_par <= ^{tgt_dph.ad, tgt_dph.cbe_n};
         tgt_par_oe <= tgt_dph.drive;
      end
   end

   // ========================================
   // Initiator timeout and read parity check
   assign abort = mst_valid & ~dsel_q & ~mst_devsel & (tmo_q == TMO_LIM);
   assign op_end = mst_valid & (mst_done | abort);
   assign rdat = abort ? '1 : mst_rdata;

   always_ff @(posedge mclk) begin
      if (reset || op_end || !mst_valid) begin
         tmo_q <= '0;
         dsel_q <= 1'b0;
      end else begin
         if (!dsel_q && !mst_devsel) tmo_q <= tmo_q + 1'b1;
         if (mst_devsel) dsel_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         chk_q <= 1'b0;
         exp_q <= 1'b0;
      end else begin
         chk_q <= op_end & ~abort & ~mst_req.cmd[0];
         exp_q <= ^{mst_rdata, mst_req.cbe_n};
      end
   end

   // ========================================
   // Line buffer
   assign use_lb = lb_en_q & lb_req.mem;
   assign reqm = lb_req.addr[2] ? {lb_req.be, 4'h0} : {4'h0, lb_req.be};
   assign wpart = |wmask_q;
   assign wfull = wmask_q == BE_ALL;
   assign w_conf = wpart & ((wtag_q != lb_req.addr[31:2]) | |(wmask_q & lb_req.be));
   assign hit = |rv_q && tag_q == lb_req.addr[31:LINE_AW] && (rv_q & reqm) == reqm;

   always_ff @(posedge mclk) begin
      if (reset) begin
         dack_q <= 1'b1;
         dflush_q <= 1'b0;
      end else begin
         dack_q <= dack_n;
         dflush_q <= (dack_n & ~dack_q & last_wr_q & wpart)
                     | (dflush_q & st_q != L_FLUSH);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q <= L_IDLE;
         mst_valid <= 1'b0;
         mst_req <= '0;
         lb_done <= 1'b0;
         lb_rdata <= '0;
         line_q <= '0;
         rv_q <= '0;
         tag_q <= '0;
         wtag_q <= '0;
         wmask_q <= '0;
         last_wr_q <= 1'b0;
      end else begin
         lb_done <= 1'b0;
         unique case (st_q)
            L_IDLE: begin
               // Flush before anything that would reorder the held write
               if (wfull || (wpart && (dflush_q || (lb_valid
                   && (!use_lb || !lb_req.write || w_conf))))) begin
                  st_q <= L_FLUSH;
                  mst_valid <= 1'b1;
                  mst_req <= mk(CMD_MW, {wtag_q, 2'b00}, line_q[WR_BYTES-1:0], ~wmask_q);
               end else if (lb_valid && !use_lb) begin
                  st_q <= L_PASS;
                  mst_valid <= 1'b1;
                  mst_req <= mk(lb_req.mem ? (lb_req.write ? CMD_MW : CMD_MR)
                                : (lb_req.write ? CMD_IOW : CMD_IOR),
                                lb_req.addr, lb_req.data, ~lb_req.be);
               end else if (lb_valid && !lb_req.write) begin
                  if (hit) begin
                     lb_rdata <= lb_req.addr[2] ? line_q[LINE_BYTES-1:WR_BYTES]
                                                : line_q[WR_BYTES-1:0];
                     rv_q <= rv_q & ~reqm;
                     lb_done <= 1'b1;
                     last_wr_q <= 1'b0;
                     st_q <= L_RESP;
                  end else begin
                     st_q <= L_F0;
                     mst_valid <= 1'b1;
                     mst_req <= mk(CMD_MR, lb_req.addr & ~LINE_MASK, '0, '0);
                  end
               end else if (lb_valid) begin
                  for (int i = 0; i < WR_BYTES; i++) begin
                     if (lb_req.be[i]) line_q[i] <= lb_req.data[8*i +: 8];
                  end
                  wmask_q <= wmask_q | lb_req.be;
                  wtag_q <= lb_req.addr[31:2];
                  rv_q <= '0;
                  lb_done <= 1'b1;
                  last_wr_q <= 1'b1;
                  st_q <= L_RESP;
               end
            end
            L_FLUSH: if (op_end) begin
               mst_valid <= 1'b0;
               wmask_q <= '0;
               st_q <= L_IDLE;
            end
            L_F0: if (op_end) begin
               line_q[WR_BYTES-1:0] <= rdat;
               mst_req <= mk(CMD_MR, mst_req.addr | DW_STEP, '0, '0);
               st_q <= L_F1;
            end
            L_F1: if (op_end) begin
               line_q[LINE_BYTES-1:WR_BYTES] <= rdat;
               rv_q <= '1;
               tag_q <= lb_req.addr[31:LINE_AW];
               mst_valid <= 1'b0;
               st_q <= L_IDLE;
            end
            L_PASS: if (op_end) begin
               mst_valid <= 1'b0;
               lb_rdata <= rdat;
               lb_done <= 1'b1;
               last_wr_q <= lb_req.write;
               st_q <= L_RESP;
            end
            L_RESP: st_q <= L_IDLE;
         endcase
      end
   end

   // ========================================
   // Assertions
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   a_retry_while_full: assert property (tgt_valid && claim && isa_wr_valid |=> tgt_rsp.retry)
      else $error("claimed cycle not retried while posted buffer full");
   a_no_post_owned: assert property (isa_gnt && tgt_valid |=> !tgt_rsp.post)
      else $error("write posted while ISA master owns bus");
   a_grant_after_drain: assert property ($rose(isa_gnt) |-> $past(!isa_wr_valid))
      else $error("grant given with posted data pending");
   a_abort_flags: assert property (abort |=> mabt_q ##0 !mst_valid || st_q == L_F1)
      else $error("master abort not recorded");
   a_tmo_bound: assert property (mst_valid |-> tmo_q <= TMO_LIM)
      else $error("devsel wait exceeded timeout");
   a_par_delay: assert property (tgt_par_oe |-> tgt_par == $past(^{tgt_dph.ad, tgt_dph.cbe_n}))
      else $error("target parity wrong or late");
   a_fetch_pair: assert property (st_q == L_F0 && op_end |=> st_q == L_F1 && mst_valid)
      else $error("second doubleword not fetched");
   a_hit_clears: assert property (st_q == L_IDLE && lb_valid && lb_req.write == 1'b0
      && use_lb && !wpart && !dflush_q && hit |=> (rv_q & $past(reqm)) == '0 ##0 lb_done)
      else $error("hit bytes still valid");
   a_read_flush: assert property (st_q == L_IDLE && lb_valid && !lb_req.write && wpart
      |=> st_q == L_FLUSH)
      else $error("read after partial write did not flush");
   a_full_flush: assert property (st_q == L_IDLE && wfull |=> st_q == L_FLUSH ##0 mst_valid)
      else $error("full write line not flushed");
   a_dock_pos: assert property (dock_q && tgt_valid |=> tgt_rsp.claim && !tgt_rsp.subtr)
      else $error("docking mode used subtractive decode");
endmodule // pci_isa_buffer_decode
`default_nettype wire

// ==== tb/pci_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pci_far_model (
   input wire logic mclk,
   input wire logic reset,
   input wire logic mst_valid,
   input wire bridge_pkg::mst_req_t mst_req,
   output logic mst_devsel,
   output logic mst_done,
   output logic [31:0] mst_rdata,
   output logic mst_rpar,
   input wire logic isa_wr_valid,
   output logic isa_wr_ready,
   input wire logic abort,
   input wire logic badpar,
   input wire logic [3:0] slow,
   input wire logic stall
);
   import bridge_pkg::*;
   logic busy_q;
   logic [3:0] cnt_q;
   logic [31:0] pat_q;
   // ========================================
   // PCI target: claims, then answers after slow extra clocks
   always_ff @(posedge mclk) begin
      mst_done <= 1'b0;
      if (reset || mst_done || abort) begin
         mst_devsel <= 1'b0;
         busy_q <= 1'b0;
      end else if (mst_valid) begin
         mst_devsel <= 1'b1;
         busy_q <= 1'b1;
         cnt_q <= busy_q ? cnt_q + 4'h1 : 4'h0;
         mst_done <= busy_q && cnt_q >= slow;
      end
   end
   // ========================================
   // Released data lines keep moving so stale data never matches
   always_ff @(posedge mclk) begin
      pat_q <= reset ? 32'h5a5a_a5a5 : pat_q + 32'h0101_0101;
      mst_rpar <= ^{mst_rdata, mst_req.cbe_n} ^ badpar;
   end
   assign mst_rdata = mst_done ? ~mst_req.addr : pat_q;
   // ========================================
   // ISA side takes a posted entry unless stalled
   always_ff @(posedge mclk) begin
      isa_wr_ready <= !reset && isa_wr_valid && !isa_wr_ready && !stall;
   end
endmodule // pci_far_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import bridge_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, tgt_par, tgt_par_oe;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, lb_rdata, mst_rdata;
   logic tgt_valid = 0, isa_mreq = 0, dack_n = 1, lb_valid = 0;
   tgt_req_t tgt_req = '0;
   tgt_rsp_t tgt_rsp;
   tgt_dph_t tgt_dph = '0;
   lb_req_t lb_req = '0;
   isa_wr_t isa_wr;
   mst_req_t mst_req;
   logic isa_wr_valid, isa_wr_ready, isa_gnt, lb_done, mst_valid, mst_devsel, mst_done, mst_rpar;
   logic abort = 0, badpar = 0, stall = 0, pe = 0, iope = 0, ssel = 0, dock = 0;
   logic [3:0] slow = '0;
   logic [39:0] ops[$];
   int seed = 64694;
   int err_count = 0, num_checks = 0, cyc = 0;
   always #2.5 mclk = ~mclk;
   pci_isa_buffer_decode #(.MABORT_CLKS(4)) dut (.mclk, .reset, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .tgt_valid, .tgt_req, .tgt_rsp, .tgt_dph, .tgt_par,
      .tgt_par_oe, .isa_wr_valid, .isa_wr, .isa_wr_ready, .isa_mreq, .isa_gnt, .dack_n,
      .lb_valid, .lb_req, .lb_done, .lb_rdata, .mst_valid, .mst_req, .mst_devsel, .mst_done,
      .mst_rdata, .mst_rpar);
   pci_far_model far (.mclk, .reset, .mst_valid, .mst_req, .mst_devsel, .mst_done, .mst_rdata,
      .mst_rpar, .isa_wr_valid, .isa_wr_ready, .abort, .badpar, .slow, .stall);
   // ========================================
   // Checking and closing
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("Checks %0d, errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (mst_valid && mst_done) begin
         ops.push_back({mst_req.cmd, mst_req.addr, mst_req.cbe_n});
         chk(40'({mst_req.apar, mst_req.dpar}), 40'({^{mst_req.addr, mst_req.cmd},
            ^{mst_req.data, mst_req.cbe_n}}));
         // Every written lane carries the lane of the one stimulus word
         if (mst_req.cmd[0]) chk(40'((mst_req.data ^ 32'h4433_2211) & ~{{8{mst_req.cbe_n[3]}},
            {8{mst_req.cbe_n[2]}}, {8{mst_req.cbe_n[1]}}, {8{mst_req.cbe_n[0]}}}), 40'h0);
      end
      if (cyc > 30000) begin
         err_count++;
         results();
      end
   end
   // ========================================
   // Register bus master
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'b111;
      do begin
         @(posedge mclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      do begin
         @(posedge mclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      {d, r} = {rdata, rresp};
      rready <= 1'b0;
   endtask
   task automatic setc(input logic [2:0] b, input logic s, input logic k);
      logic [1:0] r;
      axw(OFS_BUF, {29'h0, b}, r);
      axw(OFS_DEC, {25'h0, s, 6'h0}, r);
      axw(OFS_DOCK, {31'h0, k}, r);
      chk(40'(r), 40'(RESP_OK));
      {iope, pe, ssel, dock} = {b[1:0], s, k};
   endtask
   // ========================================
   // PCI target cycle against the decode model
   task automatic tgt(input tgt_req_t q);
      logic p, g, pos, cl, po;
      @(posedge mclk);
      tgt_valid <= 1'b1;
      tgt_req <= q;
      tgt_dph <= 37'({$random(seed), $random(seed)});
      @(posedge mclk);
      {p, g} = {isa_wr_valid, isa_gnt};
      tgt_valid <= 1'b0;
      #1;
      pos = dock | q.cfg | q.ide | q.usb | ((q.inta | q.int_io) & ~ssel);
      cl = pos | (~dock & ~q.other);
      po = cl & ~p & ~g & ~isa_mreq & pe & ~(q.cfg | q.ide | q.usb | q.inta | q.int_io | q.dma_reg)
         & (q.cmd == CMD_MW || q.cmd == CMD_MWI || (q.cmd == CMD_IOW && q.io_post && iope));
      chk(40'(tgt_rsp), 40'({1'b1, cl, cl & ~pos, cl & p, po}));
      chk(40'({tgt_par, tgt_par_oe}), 40'({^{tgt_dph.ad, tgt_dph.cbe_n}, tgt_dph.drive}));
   endtask
   // ========================================
   // ISA/DMA master access and expected PCI operations
   task automatic lbx(input logic w, m, input logic [31:0] a, input logic [3:0] be,
         output logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      slow <= 4'($random(seed)) & 4'h3;
      lb_valid <= 1'b1;
      lb_req <= '{addr: a, data: 32'h4433_2211, be: be, write: w, mem: m};
      do begin
         @(posedge mclk);
         n++;
      end while (lb_done !== 1'b1 && n < 200);
      d = lb_rdata & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      lb_valid <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic opx(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b);
      int n;
      n = 0;
      while (ops.size() == 0 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      chk(ops.size() > 0 ? ops.pop_front() : 40'h0, {c, a, b});
   endtask
   // ========================================
   // Main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      tgt_req_t q;
      logic [3:0] cmds[5];
      cmds = '{CMD_MW, CMD_MWI, CMD_IOW, CMD_IOR, CMD_MR};
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1 chk(40'({awready, wready, arready, bvalid, rvalid, isa_gnt, mst_valid}), 40'h70);
      axr(8'h10, d, r);
      chk({d, 6'h0, r}, {38'h0, RESP_SLVERR});
      for (int i = 0; i < 120; i++) begin
         if (i % 20 == 0) setc(3'($random(seed)) & 3'h3, 1'($random(seed)), i % 40 == 20);
         stall = 1'($random(seed));
         q = '0;
         q.cmd = cmds[($random(seed) & 32'hff) % 5];
         q.addr = $random(seed);
         q.be = BE_ALL;
         q[7:0] = 8'($random(seed)) & 8'($random(seed)) & 8'($random(seed));
         tgt(q);
      end
      // Grant waits for the posted entry to drain
      stall = 1'b0;
      setc(3'h1, 1'b0, 1'b0);
      repeat (10) @(posedge mclk);
      stall = 1'b1;
      q = '0;
      q.cmd = CMD_MW;
      tgt(q);
      isa_mreq <= 1'b1;
      repeat (6) @(posedge mclk);
      chk(40'(isa_gnt), 40'h0);
      stall = 1'b0;
      for (int n = 0; n < 50 && isa_gnt !== 1'b1; n++) @(posedge mclk);
      chk(40'({isa_gnt, isa_wr_valid}), 40'h2);
      tgt(q);
      isa_mreq <= 1'b0;
      // Line buffer reads
      setc(3'h4, 1'b0, 1'b0);
      dack_n <= 1'b0;
      lbx(0, 1, 32'h101, 4'h2, d);
      opx(CMD_MR, 32'h100, 4'h0);
      opx(CMD_MR, 32'h104, 4'h0);
      chk(40'(d), 40'(~32'h100 & 32'h0000_ff00));
      lbx(0, 1, 32'h104, 4'hf, d);
      chk({d, 8'(ops.size())}, {~32'h104, 8'h0});
      lbx(0, 1, 32'h101, 4'h2, d);
      opx(CMD_MR, 32'h100, 4'h0);
      opx(CMD_MR, 32'h104, 4'h0);
      // Line buffer writes and flushes
      for (int k = 0; k < 4; k++) lbx(1, 1, 32'h200, 4'(1 << k), d);
      opx(CMD_MW, 32'h200, 4'h0);
      lbx(1, 1, 32'h200, 4'h1, d);
      lbx(0, 1, 32'h300, 4'hf, d);
      opx(CMD_MW, 32'h200, 4'he);
      opx(CMD_MR, 32'h300, 4'h0);
      opx(CMD_MR, 32'h304, 4'h0);
      lbx(1, 1, 32'h200, 4'h2, d);
      lbx(1, 1, 32'h200, 4'h2, d);
      opx(CMD_MW, 32'h200, 4'hd);
      dack_n <= 1'b1;
      opx(CMD_MW, 32'h200, 4'hd);
      dack_n <= 1'b0;
      lbx(1, 1, 32'h210, 4'h1, d);
      lbx(1, 1, 32'h220, 4'h2, d);
      opx(CMD_MW, 32'h210, 4'he);
      lbx(1, 0, 32'h40, 4'h1, d);
      opx(CMD_MW, 32'h220, 4'hd);
      opx(CMD_IOW, 32'h40, 4'he);
      setc(3'h0, 1'b0, 1'b0);
      lbx(1, 1, 32'h400, 4'h3, d);
      opx(CMD_MW, 32'h400, 4'hc);
      lbx(0, 1, 32'h300, 4'hf, d);
      opx(CMD_MR, 32'h300, 4'h0);
      // Master abort and read parity
      axr(OFS_STAT, d, r);
      chk(40'(d[1:0]), 40'h0);
      setc(3'h4, 1'b0, 1'b0);
      abort = 1'b1;
      lbx(0, 1, 32'h500, 4'hf, d);
      abort = 1'b0;
      chk(40'(d), 40'hffff_ffff);
      axr(OFS_STAT, d, r);
      chk(40'(d[1:0]), 40'h1);
      axw(OFS_STAT, 32'h1, r);
      badpar = 1'b1;
      lbx(0, 1, 32'h600, 4'hf, d);
      badpar = 1'b0;
      axr(OFS_STAT, d, r);
      chk(40'(d[1:0]), 40'h2);
      results();
   end
endmodule // testbench
`default_nettype wire
